/* rtl/gtm_pkg.sv */
package gtm_pkg;

    // ************************************************
    // Widths
    // ************************************************
    localparam int CNT_W = 16;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IDX_W = 6;

    // ************************************************
    // Register indices (byte address is four times the index)
    // ************************************************
    localparam logic [IDX_W-1:0] IDX_TIMER_STATUS_CONTROL = 6'h10;
    localparam logic [IDX_W-1:0] IDX_COUNTER_HIGH = 6'h11;
    localparam logic [IDX_W-1:0] IDX_COUNTER_LOW = 6'h12;
    localparam logic [IDX_W-1:0] IDX_MODULO_LIMIT_HIGH = 6'h13;
    localparam logic [IDX_W-1:0] IDX_MODULO_LIMIT_LOW = 6'h14;
    localparam logic [IDX_W-1:0] IDX_CHANNEL0_STATUS_CONTROL = 6'h15;
    localparam logic [IDX_W-1:0] IDX_CHANNEL0_VALUE_HIGH = 6'h16;
    localparam logic [IDX_W-1:0] IDX_CHANNEL0_VALUE_LOW = 6'h17;

    // ************************************************
    // Field positions
    // ************************************************
    localparam int FLAG_BIT = 7;
    localparam int IRQ_ENABLE_BIT = 6;
    localparam int CENTER_SELECT_BIT = 5;
    localparam int MODE_B_BIT = 5;
    localparam int MODE_A_BIT = 4;
    localparam int EDGE_LEVEL_HI_BIT = 3;
    localparam int EDGE_LEVEL_LO_BIT = 2;

    // ************************************************
    // Reset values and codes
    // ************************************************
    localparam logic [CNT_W-1:0] MODULO_RESET = 16'h0000;
    localparam logic [CNT_W-1:0] COUNT_RESET = 16'h0000;
    localparam logic [CNT_W-1:0] VALUE_RESET = 16'h0000;
    localparam logic [1:0] EDGE_LEVEL_OFF = 2'h0;
    localparam logic [1:0] EDGE_LEVEL_01 = 2'h1;
    localparam logic [1:0] EDGE_LEVEL_10 = 2'h2;
    localparam logic [1:0] EDGE_LEVEL_11 = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int FLAG_NUM = 2;
    localparam int FLAG_OVERFLOW = 0;
    localparam int FLAG_CHANNEL0 = 1;

    typedef enum logic [3:0] {
        GTM_MODE_CAPTURE = 4'b0001,
        GTM_MODE_COMPARE = 4'b0010,
        GTM_MODE_EDGE_PWM = 4'b0100,
        GTM_MODE_CENTER_PWM = 4'b1000
    } gtm_mode_t;

    typedef struct packed {
        logic irq_enable;
        logic mode_b;
        logic mode_a;
        logic [1:0] edge_level;
    } gtm_ch_ctrl_t;

    typedef struct packed {
        logic level;
        logic enable_n;
    } gtm_pin_drive_t;

endpackage : gtm_pkg

/* rtl/gtm_counter.sv */
`timescale 1ns/1ns
`default_nettype none

module gtm_counter #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Control
    input wire logic clear_in,
    input wire logic center_in,
    input wire logic [CNT_W-1:0] modulo_in,
    // Status
    output logic [CNT_W-1:0] count_out,
    output logic down_out,
    output logic wrap_out
);

    if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
        $error("gtm_counter: CNT_W must lie between 2 and 32");
    end

    logic [CNT_W-1:0] cnt_ff;
    logic down_ff;
    logic [CNT_W-1:0] top;
    logic at_top;

    // A zero limit means the counter spans its whole range
    assign top = (modulo_in == '0) ? '1 : modulo_in;
    assign at_top = (cnt_ff == top);

    // Up mode wraps at the limit; center mode turns around there
    assign wrap_out = !clear_in && !down_ff && at_top;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_ff <= '0;
            down_ff <= 1'b0;
        end else if (clear_in) begin
            cnt_ff <= '0;
            down_ff <= 1'b0;
        end else if (!center_in) begin
            down_ff <= 1'b0;
            cnt_ff <= at_top ? '0 : cnt_ff + 1'b1;
        end else if (!down_ff) begin
            if (at_top) begin
                down_ff <= 1'b1;
                cnt_ff <= cnt_ff - 1'b1;
            end else begin
                cnt_ff <= cnt_ff + 1'b1;
            end
        end else if (cnt_ff == '0) begin
            down_ff <= 1'b0;
            cnt_ff <= cnt_ff + 1'b1;
        end else begin
            cnt_ff <= cnt_ff - 1'b1;
        end
    end

    assign count_out = cnt_ff;
    assign down_out = down_ff;

endmodule : gtm_counter

`default_nettype wire

/* rtl/gtm_top.sv */
// Function
// RQ1 - Up mode wraps to zero, sets overflow flag
// RQ2 - Center mode counts down after limit, flags
// RQ3 - Half-written limit suppresses overflow flag and request
// RQ4 - Reset limit zero gives free-running counter
// RQ5 - Sixteen-bit limit split high and low bytes
// RQ6 - Software writes limit after overflow or reset
// RQ7 - Capture edge on pin sets event flag
// RQ8 - Compare or edge PWM match sets flag
// RQ9 - Center PWM flags on every match
// RQ10 - Request when flag set and enable one
// RQ11 - Clear flag by read-while-set then zero write
// RQ12 - New event restarts clear sequence, keeps flag
// RQ13 - Writing one to flag ignored; reset clears
// RQ14 - Bit six enables channel interrupt, reset clear
// RQ15 - Mode B selects edge PWM outside center
// RQ16 - Mode A picks capture or compare
// RQ17 - Edge/level picks edge, compare level, polarity
// RQ18 - Edge/level zero releases pin to GPIO
// RQ19 - Capture on rising, falling or both edges
// RQ20 - Compare: software only, toggle, clear, set
`timescale 1ns/1ns
`default_nettype none

module gtm_top
    import gtm_pkg::*;
(
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic ARST_N_IN,
    // AXI4-Lite write address
    input wire logic [gtm_pkg::ADDR_W-1:0] AWADDR_IN,
    input wire logic AWVALID_IN,
    output logic AWREADY_OUT,
    // AXI4-Lite write data
    input wire logic [gtm_pkg::DATA_W-1:0] WDATA_IN,
    input wire logic [3:0] WSTRB_IN,
    input wire logic WVALID_IN,
    output logic WREADY_OUT,
    // AXI4-Lite write response
    output logic [1:0] BRESP_OUT,
    output logic BVALID_OUT,
    input wire logic BREADY_IN,
    // AXI4-Lite read address
    input wire logic [gtm_pkg::ADDR_W-1:0] ARADDR_IN,
    input wire logic ARVALID_IN,
    output logic ARREADY_OUT,
    // AXI4-Lite read data
    output logic [gtm_pkg::DATA_W-1:0] RDATA_OUT,
    output logic [1:0] RRESP_OUT,
    output logic RVALID_OUT,
    input wire logic RREADY_IN,
    // Channel 0 pin
    input wire logic CH0_PIN_IN,
    output logic CH0_PIN_OUT,
    output logic CH0_PIN_OE_N_OUT,
    // Interrupt requests
    output logic OVF_IRQ_OUT,
    output logic CH0_IRQ_OUT
);

    import gtm_pkg::*;

    // ************************************************
    // Declarations
    // ************************************************
    logic aw_got_ff;
    logic w_got_ff;
    logic [ADDR_W-1:0] aw_addr_ff;
    logic [BYTE_W-1:0] w_byte_ff;
    logic w_lane_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic [1:0] rresp_ff;

    logic ovf_ie_ff;
    logic center_ff;
    logic [BYTE_W-1:0] mod_hi_ff;
    logic [BYTE_W-1:0] mod_lo_ff;
    logic mod_wait_lo_ff;
    logic mod_wait_hi_ff;
    gtm_ch_ctrl_t ch_ctrl_ff;
    logic [CNT_W-1:0] ch_val_ff;
    logic pin_prev_ff;
    gtm_pin_drive_t pin_ff;
    gtm_pin_drive_t nxt_pin;

    logic [FLAG_NUM-1:0] flag_ff;
    logic [FLAG_NUM-1:0] armed_ff;
    logic [FLAG_NUM-1:0] flag_set;
    logic [FLAG_NUM-1:0] flag_arm;
    logic [FLAG_NUM-1:0] flag_zero_wr;

    logic aw_take;
    logic w_take;
    logic wr_fire;
    logic ar_take;
    logic [IDX_W-1:0] wr_idx;
    logic [IDX_W-1:0] rd_idx;
    logic wr_aligned;
    logic rd_aligned;
    logic wr_hit;
    logic rd_hit;
    logic [BYTE_W-1:0] rd_byte;

    logic cnt_clear;
    logic [CNT_W-1:0] cnt;
    logic cnt_down;
    logic cnt_wrap;
    logic mod_pending;
    gtm_mode_t mode;
    logic match;
    logic rise;
    logic fall;
    logic cap_event;

    // ************************************************
    // AXI4-Lite slave
    // ************************************************
    // Address and data are taken in either order; the response waits for both
    assign AWREADY_OUT = !aw_got_ff && !bvalid_ff;
    assign WREADY_OUT = !w_got_ff && !bvalid_ff;
    assign aw_take = AWVALID_IN && AWREADY_OUT;
    assign w_take = WVALID_IN && WREADY_OUT;
    assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
    assign ARREADY_OUT = !rvalid_ff;
    assign ar_take = ARVALID_IN && ARREADY_OUT;

    assign wr_idx = aw_addr_ff[ADDR_W-1:2];
    assign rd_idx = ARADDR_IN[ADDR_W-1:2];
    assign wr_aligned = (aw_addr_ff[1:0] == 2'h0);
    assign rd_aligned = (ARADDR_IN[1:0] == 2'h0);
    assign wr_hit = wr_aligned && (wr_idx >= IDX_TIMER_STATUS_CONTROL)
        && (wr_idx <= IDX_CHANNEL0_VALUE_LOW);
    assign rd_hit = rd_aligned && (rd_idx >= IDX_TIMER_STATUS_CONTROL)
        && (rd_idx <= IDX_CHANNEL0_VALUE_LOW);

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            aw_got_ff <= 1'b0;
            aw_addr_ff <= '0;
        end else if (aw_take) begin
            aw_got_ff <= 1'b1;
            aw_addr_ff <= AWADDR_IN;
        end else if (wr_fire) begin
            aw_got_ff <= 1'b0;
        end
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            w_got_ff <= 1'b0;
            w_byte_ff <= '0;
            w_lane_ff <= 1'b0;
        end else if (w_take) begin
            w_got_ff <= 1'b1;
            w_byte_ff <= WDATA_IN[BYTE_W-1:0];
            w_lane_ff <= WSTRB_IN[0];
        end else if (wr_fire) begin
            w_got_ff <= 1'b0;
        end
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (BREADY_IN) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Only byte lane 0 carries register data; other lanes are ignored
    logic wr_en;
    assign wr_en = wr_fire && wr_hit && w_lane_ff;

    always_comb begin
        rd_byte = '0;
        unique case (rd_idx)
            IDX_TIMER_STATUS_CONTROL: begin
                rd_byte[FLAG_BIT] = flag_ff[FLAG_OVERFLOW];
                rd_byte[IRQ_ENABLE_BIT] = ovf_ie_ff;
                rd_byte[CENTER_SELECT_BIT] = center_ff;
            end
            IDX_COUNTER_HIGH: rd_byte = cnt[CNT_W-1:BYTE_W];
            IDX_COUNTER_LOW: rd_byte = cnt[BYTE_W-1:0];
            IDX_MODULO_LIMIT_HIGH: rd_byte = mod_hi_ff;
            IDX_MODULO_LIMIT_LOW: rd_byte = mod_lo_ff;
            IDX_CHANNEL0_STATUS_CONTROL: begin
                rd_byte[FLAG_BIT] = flag_ff[FLAG_CHANNEL0];
                rd_byte[IRQ_ENABLE_BIT] = ch_ctrl_ff.irq_enable;
                rd_byte[MODE_B_BIT] = ch_ctrl_ff.mode_b;
                rd_byte[MODE_A_BIT] = ch_ctrl_ff.mode_a;
                rd_byte[EDGE_LEVEL_HI_BIT:EDGE_LEVEL_LO_BIT] = ch_ctrl_ff.edge_level;
            end
            IDX_CHANNEL0_VALUE_HIGH: rd_byte = ch_val_ff[CNT_W-1:BYTE_W];
            IDX_CHANNEL0_VALUE_LOW: rd_byte = ch_val_ff[BYTE_W-1:0];
            default: rd_byte = '0;
        endcase
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_hit ? {{(DATA_W-BYTE_W){1'b0}}, rd_byte} : '0;
            rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (RREADY_IN) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign BVALID_OUT = bvalid_ff;
    assign BRESP_OUT = bresp_ff;
    assign RVALID_OUT = rvalid_ff;
    assign RDATA_OUT = rdata_ff;
    assign RRESP_OUT = rresp_ff;

    // ************************************************
    // Timer control and modulo limit
    // ************************************************
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            ovf_ie_ff <= 1'b0;
            center_ff <= 1'b0;
        end else if (wr_en && wr_idx == IDX_TIMER_STATUS_CONTROL) begin
            ovf_ie_ff <= w_byte_ff[IRQ_ENABLE_BIT];
            center_ff <= w_byte_ff[CENTER_SELECT_BIT];
        end
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            mod_hi_ff <= MODULO_RESET[CNT_W-1:BYTE_W]; // [RQ4]
            mod_lo_ff <= MODULO_RESET[BYTE_W-1:0]; // [RQ4]
        end else if (wr_en && wr_idx == IDX_MODULO_LIMIT_HIGH) begin
            mod_hi_ff <= w_byte_ff; // [RQ5]
        end else if (wr_en && wr_idx == IDX_MODULO_LIMIT_LOW) begin
            mod_lo_ff <= w_byte_ff; // [RQ5]
        end
    end

    // Each byte write waits for its partner; the partner closes the pair
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            mod_wait_lo_ff <= 1'b0;
            mod_wait_hi_ff <= 1'b0;
        end else if (wr_en && wr_idx == IDX_MODULO_LIMIT_HIGH) begin
            mod_wait_lo_ff <= !mod_wait_hi_ff; // [RQ3]
            mod_wait_hi_ff <= 1'b0;
        end else if (wr_en && wr_idx == IDX_MODULO_LIMIT_LOW) begin
            mod_wait_hi_ff <= !mod_wait_lo_ff; // [RQ3]
            mod_wait_lo_ff <= 1'b0;
        end
    end

    assign mod_pending = mod_wait_lo_ff || mod_wait_hi_ff;

    // Writing either counter byte restarts the count, which is how software
    // avoids doubt about the first overflow after a new limit
    assign cnt_clear = wr_en && (wr_idx == IDX_COUNTER_HIGH || wr_idx == IDX_COUNTER_LOW); // [RQ6]

    gtm_counter #(
        .CNT_W(CNT_W)
    ) u_counter (
        .clk_in(CLK_IN),
        .arst_n_in(ARST_N_IN),
        .clear_in(cnt_clear),
        .center_in(center_ff), // [RQ2]
        .modulo_in({mod_hi_ff, mod_lo_ff}), // [RQ1] [RQ4]
        .count_out(cnt),
        .down_out(cnt_down),
        .wrap_out(cnt_wrap)
    );

    // ************************************************
    // Channel 0 control and value
    // ************************************************
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            ch_ctrl_ff <= '0; // [RQ14]
        end else if (wr_en && wr_idx == IDX_CHANNEL0_STATUS_CONTROL) begin
            ch_ctrl_ff.irq_enable <= w_byte_ff[IRQ_ENABLE_BIT]; // [RQ14]
            ch_ctrl_ff.mode_b <= w_byte_ff[MODE_B_BIT];
            ch_ctrl_ff.mode_a <= w_byte_ff[MODE_A_BIT];
            ch_ctrl_ff.edge_level <= w_byte_ff[EDGE_LEVEL_HI_BIT:EDGE_LEVEL_LO_BIT]; // [RQ17]
        end
    end

    always_comb begin
        if (center_ff) begin
            mode = GTM_MODE_CENTER_PWM;
        end else if (ch_ctrl_ff.mode_b) begin
            mode = GTM_MODE_EDGE_PWM; // [RQ15]
        end else if (ch_ctrl_ff.mode_a) begin
            mode = GTM_MODE_COMPARE; // [RQ16]
        end else begin
            mode = GTM_MODE_CAPTURE; // [RQ16]
        end
    end

    // Pin is sampled as a synchronous input; the edge detector needs one stage
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            pin_prev_ff <= 1'b0;
        end else begin
            pin_prev_ff <= CH0_PIN_IN;
        end
    end

    assign rise = CH0_PIN_IN && !pin_prev_ff;
    assign fall = !CH0_PIN_IN && pin_prev_ff;

    always_comb begin
        unique case (ch_ctrl_ff.edge_level)
            EDGE_LEVEL_01: cap_event = rise; // [RQ19]
            EDGE_LEVEL_10: cap_event = fall; // [RQ19]
            EDGE_LEVEL_11: cap_event = rise || fall; // [RQ19]
            default: cap_event = 1'b0; // [RQ18]
        endcase
        if (mode != GTM_MODE_CAPTURE) begin
            cap_event = 1'b0;
        end
    end

    // A capture outranks a software write landing in the same cycle
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            ch_val_ff <= VALUE_RESET;
        end else if (cap_event) begin
            ch_val_ff <= cnt;
        end else if (wr_en && wr_idx == IDX_CHANNEL0_VALUE_HIGH) begin
            ch_val_ff[CNT_W-1:BYTE_W] <= w_byte_ff;
        end else if (wr_en && wr_idx == IDX_CHANNEL0_VALUE_LOW) begin
            ch_val_ff[BYTE_W-1:0] <= w_byte_ff;
        end
    end

    assign match = (cnt == ch_val_ff) && !cnt_clear;

    // ************************************************
    // Channel 0 pin drive
    // ************************************************
    always_comb begin
        nxt_pin.level = pin_ff.level;
        nxt_pin.enable_n = (ch_ctrl_ff.edge_level == EDGE_LEVEL_OFF)
            || (mode == GTM_MODE_CAPTURE); // [RQ18]
        unique case (mode)
            GTM_MODE_COMPARE: begin
                if (match) begin
                    unique case (ch_ctrl_ff.edge_level)
                        EDGE_LEVEL_01: nxt_pin.level = !pin_ff.level; // [RQ20]
                        EDGE_LEVEL_10: nxt_pin.level = 1'b0; // [RQ20]
                        EDGE_LEVEL_11: nxt_pin.level = 1'b1; // [RQ20]
                        default: nxt_pin.level = pin_ff.level; // [RQ20]
                    endcase
                end
            end
            GTM_MODE_EDGE_PWM: begin
                // Period starts at the wrap; the match ends the active part
                if (cnt_wrap || cnt_clear) begin
                    nxt_pin.level = !ch_ctrl_ff.edge_level[0]; // [RQ17]
                end
                if (match) begin
                    nxt_pin.level = ch_ctrl_ff.edge_level[0]; // [RQ17]
                end
            end
            GTM_MODE_CENTER_PWM: begin
                if (match) begin
                    nxt_pin.level = cnt_down ^ ch_ctrl_ff.edge_level[0]; // [RQ17]
                end
            end
            default: nxt_pin.level = pin_ff.level;
        endcase
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            pin_ff <= '{level: 1'b0, enable_n: 1'b1};
        end else begin
            pin_ff <= nxt_pin;
        end
    end

    assign CH0_PIN_OUT = pin_ff.level;
    assign CH0_PIN_OE_N_OUT = pin_ff.enable_n;

    // ************************************************
    // Event flags with read-then-write-zero clearing
    // ************************************************
    assign flag_set[FLAG_OVERFLOW] = cnt_wrap && !mod_pending; // [RQ1] [RQ2] [RQ3]
    assign flag_set[FLAG_CHANNEL0] = cap_event // [RQ7]
        || (match && mode != GTM_MODE_CAPTURE); // [RQ8] [RQ9]

    assign flag_arm[FLAG_OVERFLOW] = ar_take && rd_hit && rd_idx == IDX_TIMER_STATUS_CONTROL;
    assign flag_arm[FLAG_CHANNEL0] = ar_take && rd_hit && rd_idx == IDX_CHANNEL0_STATUS_CONTROL;
    assign flag_zero_wr[FLAG_OVERFLOW] = wr_en && wr_idx == IDX_TIMER_STATUS_CONTROL
        && !w_byte_ff[FLAG_BIT];
    assign flag_zero_wr[FLAG_CHANNEL0] = wr_en && wr_idx == IDX_CHANNEL0_STATUS_CONTROL
        && !w_byte_ff[FLAG_BIT];

    for (genvar i = 0; i < FLAG_NUM; i++) begin : g_flag
        always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
            if (!ARST_N_IN) begin
                flag_ff[i] <= 1'b0; // [RQ13]
                armed_ff[i] <= 1'b0;
            end else if (flag_set[i]) begin
                // A fresh event wins and forces software to read again
                flag_ff[i] <= 1'b1; // [RQ12]
                armed_ff[i] <= 1'b0; // [RQ12]
            end else if (flag_zero_wr[i] && armed_ff[i]) begin
                flag_ff[i] <= 1'b0; // [RQ11]
                armed_ff[i] <= 1'b0;
            end else if (flag_arm[i] && flag_ff[i]) begin
                armed_ff[i] <= 1'b1; // [RQ11]
            end
        end
    end

    // ************************************************
    // Interrupt requests
    // ************************************************
    // Only the overflow request is gated by the pending limit, so a half-written limit cannot raise it
    assign OVF_IRQ_OUT = flag_ff[FLAG_OVERFLOW] && ovf_ie_ff && !mod_pending; // [RQ3]
    assign CH0_IRQ_OUT = flag_ff[FLAG_CHANNEL0] && ch_ctrl_ff.irq_enable; // [RQ10]

endmodule : gtm_top

`default_nettype wire

/* verification/gtm_pin_model.sv */
`timescale 1ns/1ns
`default_nettype none

module gtm_pin_model (
    // Clock
    input wire logic clk_in,
    // Pin level offered to the channel
    output logic pin_out
);
    // Changes only after an edge, so the device never sees a race
    initial pin_out = 1'b0;

    task automatic drive(input logic v);
        @(posedge clk_in);
        pin_out <= v;
    endtask : drive
endmodule : gtm_pin_model

`default_nettype wire

/* verification/gtm_top_chk.sv */
`timescale 1ns/1ns
`default_nettype none

module gtm_top_chk (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic ARST_N_IN,
    // Bus
    input wire logic AWREADY_OUT,
    input wire logic [1:0] BRESP_OUT,
    input wire logic BVALID_OUT,
    input wire logic BREADY_IN,
    input wire logic [gtm_pkg::ADDR_W-1:0] ARADDR_IN,
    input wire logic ARVALID_IN,
    input wire logic ARREADY_OUT,
    input wire logic [gtm_pkg::DATA_W-1:0] RDATA_OUT,
    input wire logic [1:0] RRESP_OUT,
    input wire logic RVALID_OUT,
    input wire logic RREADY_IN,
    // Pin and requests
    input wire logic CH0_PIN_OE_N_OUT,
    input wire logic OVF_IRQ_OUT,
    input wire logic CH0_IRQ_OUT
);
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!ARST_N_IN);

    aw_block_a: assert property (BVALID_OUT |-> !AWREADY_OUT) else $error("aw open");
    rd_answer_a: assert property (ARVALID_IN && ARREADY_OUT |=> RVALID_OUT) else $error("no read");
    b_hold_a: assert property (BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT))
        else $error("b dropped");
    r_hold_a: assert property (RVALID_OUT && !RREADY_IN |=> RVALID_OUT && $stable(RDATA_OUT))
        else $error("r dropped");
    unmapped_rd_a: assert property (ARVALID_IN && ARREADY_OUT && ARADDR_IN < 8'h40
        |=> RRESP_OUT == 2'h2 && RDATA_OUT == 32'h0) else $error("bad unmapped read");
    ch_irq_hold_a: assert property (CH0_IRQ_OUT |=> CH0_IRQ_OUT || $rose(BVALID_OUT))
        else $error("channel request lost");
    ovf_irq_hold_a: assert property (OVF_IRQ_OUT |=> OVF_IRQ_OUT || $rose(BVALID_OUT))
        else $error("overflow request lost");
    pin_release_a: assert property ($changed(CH0_PIN_OE_N_OUT)
        |-> $past(BVALID_OUT) && !$past(BVALID_OUT, 2)) else $error("pin enable moved");

    cover property ($rose(CH0_IRQ_OUT));
    cover property ($rose(OVF_IRQ_OUT));
    cover property ($fell(CH0_PIN_OE_N_OUT));
endmodule : gtm_top_chk

bind gtm_top gtm_top_chk gtm_top_chk_i (.CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN),
    .AWREADY_OUT(AWREADY_OUT), .BRESP_OUT(BRESP_OUT), .BVALID_OUT(BVALID_OUT),
    .BREADY_IN(BREADY_IN), .ARADDR_IN(ARADDR_IN), .ARVALID_IN(ARVALID_IN),
    .ARREADY_OUT(ARREADY_OUT), .RDATA_OUT(RDATA_OUT), .RRESP_OUT(RRESP_OUT),
    .RVALID_OUT(RVALID_OUT), .RREADY_IN(RREADY_IN), .CH0_PIN_OE_N_OUT(CH0_PIN_OE_N_OUT),
    .OVF_IRQ_OUT(OVF_IRQ_OUT), .CH0_IRQ_OUT(CH0_IRQ_OUT));

`default_nettype wire

/* verification/gtm_top_tb.sv */
`timescale 1ns/1ns
`default_nettype none

module gtm_top_tb;
    import gtm_pkg::*;
    logic clk, arst_n, awv, wv, bready, arv, rready, awr, wrdy, bv, arr, rv;
    logic pin_o, oe_n, ovf_irq, ch_irq, mdl, pin_w;
    logic [7:0] awaddr, araddr, r;
    logic [31:0] wdata, rdata;
    logic [1:0] rresp, rr, bresp, br;
    int num_errors, checks_done;
    // Released pin follows the outside world, else the device
    assign pin_w = oe_n ? mdl : pin_o;

    gtm_top gtm_top_i (.CLK_IN(clk), .ARST_N_IN(arst_n), .AWADDR_IN(awaddr), .AWVALID_IN(awv),
        .AWREADY_OUT(awr), .WDATA_IN(wdata), .WSTRB_IN(4'hf), .WVALID_IN(wv),
        .WREADY_OUT(wrdy), .BRESP_OUT(bresp), .BVALID_OUT(bv), .BREADY_IN(bready),
        .ARADDR_IN(araddr), .ARVALID_IN(arv), .ARREADY_OUT(arr), .RDATA_OUT(rdata),
        .RRESP_OUT(rresp), .RVALID_OUT(rv), .RREADY_IN(rready), .CH0_PIN_IN(pin_w),
        .CH0_PIN_OUT(pin_o), .CH0_PIN_OE_N_OUT(oe_n), .OVF_IRQ_OUT(ovf_irq),
        .CH0_IRQ_OUT(ch_irq));
    gtm_pin_model gtm_pin_model_i (.clk_in(clk), .pin_out(mdl));

    // ****************
    // Bus tasks
    // ****************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        awaddr <= a;
        wdata <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        fork
            begin
                do @(posedge clk); while (!awr);
                awv <= 1'b0;
            end
            begin
                do @(posedge clk); while (!wrdy);
                wv <= 1'b0;
            end
        join
        do @(posedge clk); while (!bv);
        br = bresp;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arv <= 1'b1;
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        do @(posedge clk); while (!rv);
        r = rdata[7:0];
        rr = rresp;
    endtask : rd

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic final_report;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        final_report();
    end

    initial begin
        {arst_n, awv, wv, arv, awaddr, araddr, wdata} = '0;
        // Responses are accepted the edge they appear
        {bready, rready} = 2'b11;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rd(8'h4c);
        chk(r, 8'h00);
        rd(8'h54);
        chk(r, 8'h00);
        rd(8'h00);
        chk(rr, RESP_SLVERR);
        wr(8'h00, 8'h00);
        chk(br, RESP_SLVERR);
        wr(8'h4c, 8'hab);
        chk(br, RESP_OKAY);
        wr(8'h50, 8'hcd);
        rd(8'h4c);
        chk(r, 8'hab);
        rd(8'h50);
        chk(r, 8'hcd);
        // Counter cleared first so the first wrap time is known
        wr(8'h48, 8'h00);
        wr(8'h4c, 8'h00);
        wr(8'h50, 8'h20);
        wr(8'h40, 8'h40);
        repeat (40) @(posedge clk);
        rd(8'h40);
        chk(r[7], 1'b1);
        wr(8'h4c, 8'h00);
        wr(8'h40, 8'h40);
        repeat (80) @(posedge clk);
        chk(ovf_irq, 1'b0);
        wr(8'h50, 8'h20);
        repeat (40) @(posedge clk);
        chk(ovf_irq, 1'b1);
        for (int c = 1; c < 4; c++) begin
            for (int e = 0; e < 2; e++) begin
                gtm_pin_model_i.drive(e[0]);
                repeat (3) @(posedge clk);
                wr(8'h54, {4'h4, c[1:0], 2'h0});
                rd(8'h54);
                wr(8'h54, {4'h4, c[1:0], 2'h0});
                gtm_pin_model_i.drive(!e[0]);
                repeat (4) @(posedge clk);
                chk(ch_irq, e ? c[1] : c[0]);
            end
        end
        wr(8'h54, 8'h4c);
        chk(ch_irq, 1'b1);
        wr(8'h54, 8'h0c);
        chk(ch_irq, 1'b0);
        rd(8'h54);
        chk(r, 8'h8c);
        wr(8'h54, 8'hcc);
        chk(ch_irq, 1'b1);
        rd(8'h54);
        wr(8'h54, 8'h4c);
        chk(ch_irq, 1'b0);
        wr(8'h5c, 8'h08);
        wr(8'h54, 8'h5c);
        repeat (40) @(posedge clk);
        chk(pin_o, 1'b1);
        chk(oe_n, 1'b0);
        chk(ch_irq, 1'b1);
        wr(8'h54, 8'h58);
        repeat (40) @(posedge clk);
        chk(pin_o, 1'b0);
        wr(8'h54, 8'h68);
        @(posedge clk);
        chk(oe_n, 1'b0);
        wr(8'h54, 8'h50);
        @(posedge clk);
        chk(oe_n, 1'b1);
        // Center mode: high-true output rises on the down match at 8
        wr(8'h48, 8'h00);
        wr(8'h54, 8'h48);
        rd(8'h40);
        wr(8'h40, 8'h60);
        @(posedge ovf_irq);
        repeat (30) @(posedge clk);
        chk(pin_o, 1'b1);
        repeat (20) @(posedge clk);
        chk(pin_o, 1'b0);
        final_report();
    end
endmodule : gtm_top_tb

`default_nettype wire
